// ### fpz_regs.svh
`ifndef FPZ_REGS_SVH
`define FPZ_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FPZ_OFS_DUTY_NOW      8'h30
`define FPZ_OFS_CONTROL       8'h40
`define FPZ_OFS_STATUS1       8'h41
`define FPZ_OFS_STATUS2       8'h42
`define FPZ_OFS_Z1_FLOOR      8'h4E
`define FPZ_OFS_Z1_CEILING    8'h4F
`define FPZ_OFS_Z2_FLOOR      8'h50
`define FPZ_OFS_Z2_CEILING    8'h51
`define FPZ_OFS_TACH_LO       8'h54
`define FPZ_OFS_TACH_HI       8'h55
`define FPZ_OFS_FAN_SETUP     8'h5C
`define FPZ_OFS_TACH_MODE     8'h5D

// ****************************************************************
// Reset values
// ****************************************************************
`define FPZ_RST_DUTY          8'hFF
`define FPZ_RST_FLOOR         8'h81
`define FPZ_RST_CEILING       8'h7F
`define FPZ_RST_TACH_BYTE     8'hFF
`define FPZ_RST_FAN_SETUP     8'h62
`define FPZ_DUTY_ZERO         8'h00
`define FPZ_TACH_MUTE         16'hFFFF

// ****************************************************************
// Field positions
// ****************************************************************
`define FPZ_CTL_START         0
`define FPZ_CTL_LOCK          1
`define FPZ_CTL_OVERRIDE      3
`define FPZ_ST1_ZONE1         0
`define FPZ_ST1_ZONE2         1
`define FPZ_ST2_FAN           0
`define FPZ_TM_THREE_WIRE     0
`define FPZ_SETUP_MODE_HI     7
`define FPZ_SETUP_MODE_LO     5
`define FPZ_SETUP_POLARITY    4
`define FPZ_SETUP_SPIN_HI     2

// ****************************************************************
// Timing
// ****************************************************************
`define FPZ_CLK_HZ            25000000
`define FPZ_MS_PER_S          1000
`define FPZ_MS_CYCLES         (`FPZ_CLK_HZ / `FPZ_MS_PER_S)
`define FPZ_SPIN_MS_0         12'd0
`define FPZ_SPIN_MS_1         12'd100
`define FPZ_SPIN_MS_2         12'd250
`define FPZ_SPIN_MS_3         12'd400
`define FPZ_SPIN_MS_4         12'd700
`define FPZ_SPIN_MS_5         12'd1000
`define FPZ_SPIN_MS_6         12'd2000
`define FPZ_SPIN_MS_7         12'd4000
`define FPZ_PWM_TOP           8'hFE

`endif

// ### fpz_pkg.sv
`default_nettype none
package fpz_pkg;

    typedef enum logic [6:0] {
        FPZ_MODE_Z1   = 7'b0000001,
        FPZ_MODE_Z2   = 7'b0000010,
        FPZ_MODE_RSVD = 7'b0000100,
        FPZ_MODE_FULL = 7'b0001000,
        FPZ_MODE_OFF  = 7'b0010000,
        FPZ_MODE_HOT  = 7'b0100000,
        FPZ_MODE_MAN  = 7'b1000000
    } fpz_mode_t;

    function automatic fpz_mode_t fpz_decode_mode(input logic [2:0] code);
        case (code)
            3'h0:        fpz_decode_mode = FPZ_MODE_Z1;
            3'h1, 3'h5:  fpz_decode_mode = FPZ_MODE_Z2;
            3'h2:        fpz_decode_mode = FPZ_MODE_RSVD;
            3'h3:        fpz_decode_mode = FPZ_MODE_FULL;
            3'h4:        fpz_decode_mode = FPZ_MODE_OFF;
            3'h6:        fpz_decode_mode = FPZ_MODE_HOT;
            default:     fpz_decode_mode = FPZ_MODE_MAN;
        endcase
    endfunction

endpackage
`default_nettype wire

// ### fpz_pwm_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpz_regs.svh"
module fpz_pwm_gen (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Duty in, raw waveform out
    input  wire logic [7:0] duty,
    output logic            pwm_raw
);

    logic [7:0] cnt_reg;

    // ****************************************************************
    // Period of 255 counts
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg == `FPZ_PWM_TOP) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // High for duty of the 255 counts
    assign pwm_raw = (cnt_reg < duty); // R20 R04

endmodule
`default_nettype wire

// ### fpz_spinup.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpz_regs.svh"
module fpz_spinup #(
    parameter int MS_CYCLES = `FPZ_MS_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Start request and time select
    input  wire logic       kick,
    input  wire logic [2:0] spin_sel,
    output logic            active
);

    logic [24:0] pre_reg;
    logic [11:0] ms_left_reg;

    function automatic logic [11:0] spin_ms(input logic [2:0] sel);
        case (sel)
            3'h0:    spin_ms = `FPZ_SPIN_MS_0;
            3'h1:    spin_ms = `FPZ_SPIN_MS_1;
            3'h2:    spin_ms = `FPZ_SPIN_MS_2;
            3'h3:    spin_ms = `FPZ_SPIN_MS_3;
            3'h4:    spin_ms = `FPZ_SPIN_MS_4;
            3'h5:    spin_ms = `FPZ_SPIN_MS_5;
            3'h6:    spin_ms = `FPZ_SPIN_MS_6;
            default: spin_ms = `FPZ_SPIN_MS_7;
        endcase
    endfunction

    // ****************************************************************
    // Millisecond countdown
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_reg     <= 25'h0000000;
            ms_left_reg <= 12'h000;
        end else if (kick) begin
            pre_reg     <= 25'h0000000;
            ms_left_reg <= spin_ms(spin_sel); // R19
        end else if (ms_left_reg != 12'h000) begin
            if (pre_reg == 25'(MS_CYCLES - 1)) begin
                pre_reg     <= 25'h0000000;
                ms_left_reg <= ms_left_reg - 12'h001;
            end else begin
                pre_reg <= pre_reg + 25'h0000001;
            end
        end
    end

    assign active = (ms_left_reg != 12'h000);

endmodule
`default_nettype wire

// ### fpz_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpz_regs.svh"
// Overview of operation
// (R01) Power-on: full duty, duty reads FFh
// (R02) Start bit: duty follows automatic control
// (R03) Duty writable only in manual mode
// (R04) 8-bit duty code, 00 off, FF full
// (R05) Three-wire tach window forces output high
// (R06) Out-of-limit zone temperature sets status flag
// (R07) Zone 1 remote diode, zone 2 internal
// (R08) Signed limits, reset +127 and -127
// (R09) Limits and tach floor ignore lock
// (R10) Tach count below floor sets fan flag
// (R11) No tach flag at zero duty, disabled
// (R12) Tach floor FFFFh never raises alert
// (R13) Lock makes fan setup read-only
// (R14) Start clear uses default fan setup
// (R15) Three-bit field selects zone or mode
// (R16) Hotter zone: larger of two PWM levels
// (R17) Disabled fan drives inactive output level
// (R18) Polarity bit inverts output sense
// (R19) Spin-up holds full duty for time
// (R20) High time is duty over 255
module fpz_top
    import fpz_pkg::*;
#(
    parameter int MS_CYCLES = `FPZ_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Zone temperatures, remote diode and internal sensor
    input  wire logic [7:0]  zone1_temp,
    input  wire logic [7:0]  zone2_temp,
    // Automatic control levels per zone
    input  wire logic [7:0]  auto_duty_z1,
    input  wire logic [7:0]  auto_duty_z2,
    // Tachometer measurement
    input  wire logic [15:0] tach_count,
    input  wire logic        tach_valid,
    input  wire logic        tach_window,
    // Fan drive
    output logic             pwm_out
);
    import fpz_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0]  duty_now_reg;
    logic [7:0]  duty_now_next;
    logic        ctl_start_reg;
    logic        ctl_lock_reg;
    logic        ctl_override_reg;
    logic [1:0]  status1_reg;
    logic        status2_reg;
    logic [7:0]  zone1_temp_floor_reg;
    logic [7:0]  zone1_temp_ceiling_reg;
    logic [7:0]  zone2_temp_floor_reg;
    logic [7:0]  zone2_temp_ceiling_reg;
    logic [7:0]  tach_floor_low_byte_reg;
    logic [7:0]  tach_floor_high_byte_reg;
    logic [7:0]  fan_setup_reg;
    logic        three_wire_reg;
    logic [7:0]  rdata_reg;
    logic        pwm_out_reg;

    logic [7:0]  cfg_eff;
    fpz_mode_t   mode;
    logic        output_polarity_flip;
    logic [2:0]  spin_sel;
    logic [15:0] tach_floor;
    logic [7:0]  hot_duty;
    logic [7:0]  applied_duty;
    logic        spin_kick;
    logic        spin_active;
    logic        pwm_raw;
    logic        zone1_limit_flag;
    logic        zone2_limit_flag;
    logic        fan_tach_flag;
    logic        fan_off;

    function automatic logic hit(input logic [7:0] a);
        hit = reg_wr && (reg_addr == a);
    endfunction

    function automatic logic out_of_band(input logic [7:0] t, input logic [7:0] lo,
                                         input logic [7:0] hi);
        out_of_band = ($signed(t) > $signed(hi)) || ($signed(t) < $signed(lo));
    endfunction

    // ****************************************************************
    // Effective configuration
    // ****************************************************************
    assign cfg_eff              = ctl_start_reg ? fan_setup_reg : `FPZ_RST_FAN_SETUP; // R14
    assign mode                 = fpz_decode_mode(cfg_eff[`FPZ_SETUP_MODE_HI:`FPZ_SETUP_MODE_LO]);
    assign output_polarity_flip = cfg_eff[`FPZ_SETUP_POLARITY];
    assign spin_sel             = cfg_eff[`FPZ_SETUP_SPIN_HI:0];
    assign tach_floor           = {tach_floor_high_byte_reg, tach_floor_low_byte_reg};
    assign fan_off              = (mode == FPZ_MODE_OFF) && !ctl_override_reg;
    assign hot_duty             = (auto_duty_z1 > auto_duty_z2) ? auto_duty_z1 : auto_duty_z2;

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_start_reg    <= 1'b0;
            ctl_lock_reg     <= 1'b0;
            ctl_override_reg <= 1'b0;
        end else if (hit(`FPZ_OFS_CONTROL)) begin
            ctl_start_reg    <= reg_wdata[`FPZ_CTL_START];
            // Lock can be set but never cleared
            ctl_lock_reg     <= ctl_lock_reg | reg_wdata[`FPZ_CTL_LOCK];
            ctl_override_reg <= reg_wdata[`FPZ_CTL_OVERRIDE];
        end
    end

    // ****************************************************************
    // Limit registers, always writable
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zone1_temp_floor_reg     <= `FPZ_RST_FLOOR; // R08
            zone1_temp_ceiling_reg   <= `FPZ_RST_CEILING;
            zone2_temp_floor_reg     <= `FPZ_RST_FLOOR;
            zone2_temp_ceiling_reg   <= `FPZ_RST_CEILING;
            tach_floor_low_byte_reg  <= `FPZ_RST_TACH_BYTE;
            tach_floor_high_byte_reg <= `FPZ_RST_TACH_BYTE;
            three_wire_reg           <= 1'b0;
        end else begin
            if (hit(`FPZ_OFS_Z1_FLOOR)) begin // R09
                zone1_temp_floor_reg <= reg_wdata;
            end
            if (hit(`FPZ_OFS_Z1_CEILING)) begin
                zone1_temp_ceiling_reg <= reg_wdata;
            end
            if (hit(`FPZ_OFS_Z2_FLOOR)) begin
                zone2_temp_floor_reg <= reg_wdata;
            end
            if (hit(`FPZ_OFS_Z2_CEILING)) begin
                zone2_temp_ceiling_reg <= reg_wdata;
            end
            if (hit(`FPZ_OFS_TACH_LO)) begin
                tach_floor_low_byte_reg <= reg_wdata;
            end
            if (hit(`FPZ_OFS_TACH_HI)) begin
                tach_floor_high_byte_reg <= reg_wdata;
            end
            if (hit(`FPZ_OFS_TACH_MODE)) begin
                three_wire_reg <= reg_wdata[`FPZ_TM_THREE_WIRE];
            end
        end
    end

    // ****************************************************************
    // Fan setup, frozen by lock
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fan_setup_reg <= `FPZ_RST_FAN_SETUP;
        end else if (hit(`FPZ_OFS_FAN_SETUP) && !ctl_lock_reg) begin // R13
            fan_setup_reg <= reg_wdata;
        end
    end

    // ****************************************************************
    // Current duty
    // ****************************************************************
    always_comb begin
        duty_now_next = duty_now_reg;
        if (ctl_override_reg || !ctl_start_reg) begin
            duty_now_next = `FPZ_RST_DUTY; // R01
        end else begin
            case (mode) // R15 R02
                FPZ_MODE_Z1:   duty_now_next = auto_duty_z1; // R07
                FPZ_MODE_Z2:   duty_now_next = auto_duty_z2;
                FPZ_MODE_HOT:  duty_now_next = hot_duty; // R16
                FPZ_MODE_OFF:  duty_now_next = `FPZ_DUTY_ZERO;
                FPZ_MODE_MAN: begin
                    if (hit(`FPZ_OFS_DUTY_NOW)) begin
                        duty_now_next = reg_wdata; // R03
                    end
                end
                default:       duty_now_next = `FPZ_RST_DUTY;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_now_reg <= `FPZ_RST_DUTY; // R01
        end else begin
            duty_now_reg <= duty_now_next;
        end
    end

    // ****************************************************************
    // Spin-up and waveform
    // ****************************************************************
    assign spin_kick    = (duty_now_reg == `FPZ_DUTY_ZERO) && (duty_now_next != `FPZ_DUTY_ZERO);
    assign applied_duty = spin_active ? `FPZ_RST_DUTY : duty_now_reg; // R19

    fpz_spinup #(
        .MS_CYCLES (MS_CYCLES)
    ) u_spinup (
        .clk      (clk),
        .rst_n    (rst_n),
        .kick     (spin_kick),
        .spin_sel (spin_sel),
        .active   (spin_active)
    );

    fpz_pwm_gen u_pwm_gen (
        .clk     (clk),
        .rst_n   (rst_n),
        .duty    (applied_duty),
        .pwm_raw (pwm_raw)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_out_reg <= 1'b1;
        end else if (fan_off) begin
            pwm_out_reg <= output_polarity_flip; // R17
        end else begin
            pwm_out_reg <= (pwm_raw | (three_wire_reg & tach_window)) // R05
                           ^ output_polarity_flip; // R18
        end
    end

    // ****************************************************************
    // Status flags, write one to clear, set wins
    // ****************************************************************
    assign zone1_limit_flag = out_of_band(zone1_temp, zone1_temp_floor_reg,
                                          zone1_temp_ceiling_reg); // R06 R07
    assign zone2_limit_flag = out_of_band(zone2_temp, zone2_temp_floor_reg,
                                          zone2_temp_ceiling_reg);
    assign fan_tach_flag    = tach_valid && (tach_count < tach_floor) // R10
                              && (tach_floor != `FPZ_TACH_MUTE) // R12
                              && (duty_now_reg != `FPZ_DUTY_ZERO) && (mode != FPZ_MODE_OFF); // R11

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status1_reg <= 2'h0;
            status2_reg <= 1'b0;
        end else begin
            status1_reg[`FPZ_ST1_ZONE1] <= zone1_limit_flag | (status1_reg[`FPZ_ST1_ZONE1]
                & ~(hit(`FPZ_OFS_STATUS1) & reg_wdata[`FPZ_ST1_ZONE1])); // R06
            status1_reg[`FPZ_ST1_ZONE2] <= zone2_limit_flag | (status1_reg[`FPZ_ST1_ZONE2]
                & ~(hit(`FPZ_OFS_STATUS1) & reg_wdata[`FPZ_ST1_ZONE2]));
            status2_reg <= fan_tach_flag | (status2_reg
                & ~(hit(`FPZ_OFS_STATUS2) & reg_wdata[`FPZ_ST2_FAN])); // R10
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n || !reg_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr)
                `FPZ_OFS_DUTY_NOW:   rdata_reg <= duty_now_reg; // R01
                `FPZ_OFS_CONTROL:    rdata_reg <= {4'h0, ctl_override_reg, 1'b0,
                                                   ctl_lock_reg, ctl_start_reg};
                `FPZ_OFS_STATUS1:    rdata_reg <= {6'h00, status1_reg};
                `FPZ_OFS_STATUS2:    rdata_reg <= {7'h00, status2_reg};
                `FPZ_OFS_Z1_FLOOR:   rdata_reg <= zone1_temp_floor_reg;
                `FPZ_OFS_Z1_CEILING: rdata_reg <= zone1_temp_ceiling_reg;
                `FPZ_OFS_Z2_FLOOR:   rdata_reg <= zone2_temp_floor_reg;
                `FPZ_OFS_Z2_CEILING: rdata_reg <= zone2_temp_ceiling_reg;
                `FPZ_OFS_TACH_LO:    rdata_reg <= tach_floor_low_byte_reg;
                `FPZ_OFS_TACH_HI:    rdata_reg <= tach_floor_high_byte_reg;
                `FPZ_OFS_FAN_SETUP:  rdata_reg <= {fan_setup_reg[7:4], 1'b0, fan_setup_reg[2:0]};
                `FPZ_OFS_TACH_MODE:  rdata_reg <= {7'h00, three_wire_reg};
                default:             rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;
    assign pwm_out   = pwm_out_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_from_stop;
        (duty_now_reg == `FPZ_DUTY_ZERO && spin_sel != 3'h0) ##1 (duty_now_reg != `FPZ_DUTY_ZERO);
    endsequence

    sequence s_locked_write;
        ctl_lock_reg && hit(`FPZ_OFS_FAN_SETUP);
    endsequence

    property p_idle_full;
        @(posedge clk) disable iff (!rst_n)
        !ctl_start_reg ##1 !ctl_start_reg |-> duty_now_reg == 8'hFF;
    endproperty
    a_idle_full: assert property (p_idle_full) else $error("duty not full before start"); // R01

    property p_auto_z1;
        @(posedge clk) disable iff (!rst_n)
        (ctl_start_reg && !ctl_override_reg && mode == FPZ_MODE_Z1)
            |=> duty_now_reg == $past(auto_duty_z1);
    endproperty
    a_auto_z1: assert property (p_auto_z1) else $error("duty not following zone 1"); // R02

    property p_manual_write;
        @(posedge clk) disable iff (!rst_n)
        (ctl_start_reg && !ctl_override_reg && mode == FPZ_MODE_MAN && hit(`FPZ_OFS_DUTY_NOW))
            |=> duty_now_reg == $past(reg_wdata);
    endproperty
    a_manual_write: assert property (p_manual_write) else $error("manual duty lost"); // R03

    property p_zone1_high;
        @(posedge clk) disable iff (!rst_n)
        $signed(zone1_temp) > $signed(zone1_temp_ceiling_reg) |=> status1_reg[0];
    endproperty
    a_zone1_high: assert property (p_zone1_high) else $error("zone 1 flag missed"); // R07

    property p_tach_mute;
        @(posedge clk) disable iff (!rst_n)
        (tach_floor == 16'hFFFF && !status2_reg) |=> !status2_reg;
    endproperty
    a_tach_mute: assert property (p_tach_mute) else $error("muted tach alerted"); // R12

    property p_tach_zero;
        @(posedge clk) disable iff (!rst_n)
        (duty_now_reg == 8'h00 && !status2_reg) |=> !status2_reg;
    endproperty
    a_tach_zero: assert property (p_tach_zero) else $error("tach flag at zero duty"); // R11

    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        s_locked_write |=> $stable(fan_setup_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("locked setup changed"); // R13

    property p_off_level;
        @(posedge clk) disable iff (!rst_n)
        fan_off |=> pwm_out_reg == $past(output_polarity_flip);
    endproperty
    a_off_level: assert property (p_off_level) else $error("disabled level wrong"); // R17

    property p_spin;
        @(posedge clk) disable iff (!rst_n)
        s_from_stop |-> spin_active ##1 (applied_duty == 8'hFF);
    endproperty
    a_spin: assert property (p_spin) else $error("spin-up not held"); // R19

endmodule
`default_nettype wire

// ### fpz_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Fan tachometer
// ****************
module fpz_fan_model (
    // Clock
    input  wire logic        clk,
    // Measurement request and speed
    input  wire logic        go,
    input  wire logic [15:0] speed,
    // Tach side
    output logic      [15:0] tach_count = 16'h0000,
    output logic             tach_valid = 1'b0,
    output logic             tach_window = 1'b0
);
    logic [3:0] win_cnt = 4'h0;

    // Count is only meaningful with the valid pulse, garbage otherwise
    always @(posedge clk) begin
        tach_valid <= (win_cnt == 4'h1);
        tach_count <= (win_cnt == 4'h1) ? speed : ~tach_count;
        tach_window <= (win_cnt != 4'h0);
        if (go)
            win_cnt <= 4'h8;
        else if (win_cnt != 4'h0)
            win_cnt <= win_cnt - 4'h1;
    end
endmodule
`default_nettype wire

// ### fan_pwm_zone_limit_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module fan_pwm_zone_limit_control_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        go = 1'b0;
    logic        pwm;
    logic        tv;
    logic        tw;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  ad1 = 8'h30;
    logic [7:0]  z1t = 8'h00;
    logic [7:0]  z2t = 8'h00;
    logic [7:0]  rdata;
    logic [15:0] tc;
    int          n_mismatch = 0;
    int          check_count = 0;
    // Rows: write flag, address, write data, expected read
    logic [27:0] ops [16] = '{28'h0_30_00_FF, 28'h0_4E_00_81, 28'h0_4F_00_7F,
        28'h0_50_00_81, 28'h0_51_00_7F, 28'h0_54_00_FF, 28'h0_55_00_FF, 28'h0_5C_00_62,
        28'h1_33_AA_00, 28'h0_33_00_00, 28'h1_4F_19_00, 28'h0_4F_00_19, 28'h1_5C_F0_00,
        28'h0_5C_00_F0, 28'h1_30_20_00, 28'h0_30_00_FF};
    // Rows: mode code, zone 1 level, expected duty
    logic [19:0] md [7] = '{20'h0_30_30, 20'h1_30_50, 20'h2_30_FF, 20'h3_30_FF,
        20'h5_30_50, 20'h6_30_50, 20'h6_70_70};

    always #20 clk = ~clk;

    fpz_top #(.MS_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .zone1_temp(z1t), .zone2_temp(z2t), .auto_duty_z1(ad1), .auto_duty_z2(8'h50),
        .tach_count(tc), .tach_valid(tv), .tach_window(tw), .pwm_out(pwm));

    fpz_fan_model fan_u (.clk(clk), .go(go), .speed(16'h0010), .tach_count(tc),
        .tach_valid(tv), .tach_window(tw));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp({8'h00, rdata}, {8'h00, e}, "register read");
    endtask

    // Counts high cycles of the fan output after a settling gap
    task automatic hc(input int s, input int n, input logic [15:0] e);
        logic [15:0] k;
        k = 16'h0000;
        repeat (s) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            #1;
            k = k + {15'h0000, pwm};
        end
        cmp(k, e, "pwm high count");
    endtask

    task automatic meas();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        hc(0, 19, 16'd19);
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (ops[i]) begin
            if (ops[i][24])
                wr(ops[i][23:16], ops[i][15:8]);
            else
                rd(ops[i][23:16], ops[i][7:0]);
        end
        // Written setup has inverted polarity, but start is clear
        hc(2, 4, 16'd4);
        @(posedge clk);
        z1t <= 8'h1A;
        z2t <= 8'h80;
        rd(8'h41, 8'h03);
        // Negative reading inside the band must not flag
        @(posedge clk);
        z1t <= 8'hF0;
        z2t <= 8'h00;
        wr(8'h41, 8'h03);
        rd(8'h41, 8'h00);
        wr(8'h5C, 8'hE1);
        wr(8'h40, 8'h01);
        wr(8'h30, 8'h00);
        rd(8'h30, 8'h00);
        hc(0, 255, 16'd0);
        wr(8'h30, 8'h80);
        hc(0, 300, 16'd300);
        hc(120, 255, 16'd128);
        meas();
        repeat (12) @(posedge clk);
        rd(8'h42, 8'h00);
        wr(8'h55, 8'h00);
        wr(8'h54, 8'h20);
        meas();
        repeat (12) @(posedge clk);
        rd(8'h42, 8'h01);
        wr(8'h42, 8'h01);
        wr(8'h30, 8'h00);
        meas();
        repeat (12) @(posedge clk);
        rd(8'h42, 8'h00);
        wr(8'h5D, 8'h01);
        meas();
        hc(0, 16, 16'd8);
        wr(8'h5D, 8'h00);
        foreach (md[i]) begin
            @(posedge clk);
            ad1 <= md[i][15:8];
            wr(8'h5C, {md[i][18:16], 5'h00});
            rd(8'h30, md[i][7:0]);
        end
        wr(8'h5C, 8'h80);
        hc(4, 255, 16'd0);
        wr(8'h5C, 8'h90);
        hc(4, 255, 16'd255);
        wr(8'h5C, 8'h70);
        hc(4, 255, 16'd0);
        wr(8'h40, 8'h03);
        wr(8'h5C, 8'h00);
        rd(8'h5C, 8'h70);
        wr(8'h4E, 8'h05);
        rd(8'h4E, 8'h05);
        @(posedge clk);
        rst_n <= 1'b0;
        hc(3, 2, 16'd2);
        @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h30, 8'hFF);
        close_out();
    end
endmodule
`default_nettype wire
